// [verilog/loop_clock_regs.sv]
// Register file, lock tracking and status flags of the frequency lock loop.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps

module loop_clock_regs (
  input  wire logic                        clk_sys,          // System clock.
  input  wire logic                        rst_b,            // System reset.
  input  wire logic                        clk_en,           // Clock enable.
  input  wire clk_gen_pkg::reg_req_s       reg_req,          // Bus request.
  output logic [clk_gen_pkg::DATA_W-1:0]   rd_data,          // Read data.
  input  wire logic                        power_on_reset,   // Power-on.
  input  wire logic                        illegal_access,   // Bad access.
  input  wire logic                        stop_mode,        // Stop mode.
  input  wire logic                        lock_in_tol,      // Async lock.
  input  wire logic                        osc_start_done,   // Async start.
  input  wire logic [clk_gen_pkg::TRIM_W-1:0] trim_factory,  // Flash trim.
  output logic [clk_gen_pkg::FACTOR_W-1:0] multiply_factor,  // Loop factor.
  output logic                             reference_select, // Ref choice.
  output logic                             bus_clock_source, // Bus source.
  output logic                             osc_enable,       // Osc on.
  output logic                             osc_monitor_en,   // Monitor on.
  output logic [clk_gen_pkg::TRIM_W-1:0]   ref_trim,         // Trim value.
  output logic                             lock_irq          // Interrupt.
);

  // ---------------------------------------------------------------------
  // Synchronisers for the analog status levels
  // ---------------------------------------------------------------------
  logic tol_meta_r;
  logic tol_sync_r;
  logic osc_meta_r;
  logic osc_sync_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tol_meta_r <= 1'b0;
      tol_sync_r <= 1'b0;
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
    end else if (clk_en) begin
      tol_meta_r <= lock_in_tol;
      tol_sync_r <= tol_meta_r;
      osc_meta_r <= osc_start_done;
      osc_sync_r <= osc_meta_r;
    end
  end

  // ---------------------------------------------------------------------
  // Control, lock and trim state
  // ---------------------------------------------------------------------
  logic [7:0]                          ctl0_r;
  logic [7:0]                          ctl0_nxt;
  logic [7:0]                          ctl1_r;
  logic [7:0]                          ctl1_nxt;
  logic [clk_gen_pkg::MULT_W-1:0]      mult_r;
  logic [clk_gen_pkg::MULT_W-1:0]      mult_nxt;
  logic [clk_gen_pkg::FACTOR_W-1:0]    factor_r;
  logic [clk_gen_pkg::FACTOR_W-1:0]    factor_nxt;
  logic [clk_gen_pkg::TRIM_W-1:0]      trim_r;
  logic [clk_gen_pkg::TRIM_W-1:0]      trim_nxt;
  clk_gen_pkg::trim_state_e            state_r;
  clk_gen_pkg::trim_state_e            state_nxt;
  logic                                lock_r;
  logic                                lock_nxt;
  logic                                relock_wait_r;
  logic                                relock_wait_nxt;
  logic                                lock_change_flag_r;
  logic                                lock_change_flag_nxt;
  logic                                started_r;
  logic                                started_nxt;
  logic                                irq_r;
  logic                                irq_nxt;
  logic [7:0]                          rd_r;
  logic [7:0]                          rd_nxt;
  logic                                power_on_flag_r;
  logic                                power_on_flag_nxt;
  logic                                illegal_access_flag_r;
  logic                                illegal_access_flag_nxt;

  logic wr_ctl0;
  logic wr_ctl1;
  logic wr_mult;
  logic wr_flags;
  logic wr_trimh;
  logic wr_triml;
  logic force_clear;

  assign wr_ctl0  = reg_req.wr && reg_req.addr == clk_gen_pkg::CTL0_OFS;
  assign wr_ctl1  = reg_req.wr && reg_req.addr == clk_gen_pkg::CTL1_OFS;
  assign wr_mult  = reg_req.wr && reg_req.addr == clk_gen_pkg::MULT_OFS;
  assign wr_flags = reg_req.wr && reg_req.addr == clk_gen_pkg::FLAGS_OFS;
  assign wr_trimh = reg_req.wr && reg_req.addr == clk_gen_pkg::TRIMH_OFS;
  assign wr_triml = reg_req.wr && reg_req.addr == clk_gen_pkg::TRIML_OFS;

  // Writes that retune the loop, and stop entry, drop lock silently.
  assign force_clear = stop_mode | wr_ctl0 | wr_mult | wr_trimh
                     | wr_triml;

  always_comb begin
    ctl0_nxt        = ctl0_r;
    ctl1_nxt        = ctl1_r;
    mult_nxt        = mult_r;
    trim_nxt        = trim_r;
    state_nxt       = state_r;
    started_nxt     = started_r;
    relock_wait_nxt = relock_wait_r;
    lock_nxt        = 1'b0;
    lock_change_flag_nxt      = lock_change_flag_r;
    rd_nxt          = 8'h00;

    if (wr_ctl0) begin
      ctl0_nxt = reg_req.wdata & clk_gen_pkg::CTL0_MASK;
      ctl0_nxt[clk_gen_pkg::BUS_SRC_BIT] =
        reg_req.wdata[clk_gen_pkg::BUS_SRC_BIT] & started_r;
      ctl0_nxt[clk_gen_pkg::REF_SEL_BIT] =
        reg_req.wdata[clk_gen_pkg::REF_SEL_BIT] & started_r;
    end
    if (!ctl0_nxt[clk_gen_pkg::OSC_EN_BIT] || stop_mode) begin
      ctl0_nxt[clk_gen_pkg::BUS_SRC_BIT] = 1'b0;
      ctl0_nxt[clk_gen_pkg::REF_SEL_BIT] = 1'b0;
    end
    if (wr_ctl1) begin
      ctl1_nxt = reg_req.wdata & clk_gen_pkg::CTL1_MASK;
    end
    if (wr_mult) begin
      mult_nxt = reg_req.wdata[clk_gen_pkg::MULT_W-1:0];
    end

    // Startup status follows the oscillator and never software.
    if (!ctl0_r[clk_gen_pkg::OSC_EN_BIT] || stop_mode) begin
      started_nxt = 1'b0;
    end else if (osc_sync_r) begin
      started_nxt = 1'b1;
    end

    case (state_r)
      clk_gen_pkg::TRIM_LOAD: begin
        trim_nxt  = trim_factory;
        state_nxt = clk_gen_pkg::TRIM_RUN;
      end
      clk_gen_pkg::TRIM_RUN: begin
        if (wr_trimh) begin
          trim_nxt[clk_gen_pkg::TRIM_HI_BIT] = reg_req.wdata[0];
        end
        if (wr_triml) begin
          trim_nxt[7:0] = reg_req.wdata;
        end
      end
      default: begin
        state_nxt = clk_gen_pkg::TRIM_LOAD;
      end
    endcase

    // After a forced clear the tolerance detector must first report a
    // miss, so a stale in-tolerance level cannot fake a new lock.
    if (force_clear) begin
      relock_wait_nxt = 1'b1;
    end else if (!tol_sync_r) begin
      relock_wait_nxt = 1'b0;
    end
    lock_nxt = !force_clear && tol_sync_r && !relock_wait_r;

    if (wr_flags && reg_req.wdata[clk_gen_pkg::LOCK_CHANGE_FLAG_BIT]) begin
      lock_change_flag_nxt = 1'b0;
    end
    if (lock_nxt != lock_r && !force_clear) begin
      lock_change_flag_nxt = 1'b1;
    end

    if (reg_req.rd) begin
      case (reg_req.addr)
        clk_gen_pkg::CTL0_OFS:  rd_nxt = ctl0_r;
        clk_gen_pkg::CTL1_OFS:  rd_nxt = ctl1_r;
        clk_gen_pkg::MULT_OFS:  rd_nxt = {1'b0, mult_r};
        clk_gen_pkg::FLAGS_OFS: rd_nxt = {1'b0, power_on_flag_r, 1'b0, lock_change_flag_r,
                                          lock_r, illegal_access_flag_r, started_r,
                                          1'b0};
        clk_gen_pkg::TRIMH_OFS: rd_nxt = {7'h00, trim_r[8]};
        clk_gen_pkg::TRIML_OFS: rd_nxt = trim_r[7:0];
        default:                rd_nxt = 8'h00;
      endcase
    end

    factor_nxt = clk_gen_pkg::MULT_BASE
               + {3'h0, mult_nxt, 1'b0};
    irq_nxt    = lock_change_flag_nxt & ctl1_nxt[clk_gen_pkg::IRQ_EN_BIT];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctl0_r        <= clk_gen_pkg::CTL0_RST;
      ctl1_r        <= clk_gen_pkg::CTL1_RST;
      mult_r        <= clk_gen_pkg::MULT_RST;
      factor_r      <= clk_gen_pkg::MULT_BASE;
      trim_r        <= clk_gen_pkg::TRIM_RST;
      state_r       <= clk_gen_pkg::TRIM_LOAD;
      started_r     <= 1'b0;
      relock_wait_r <= 1'b0;
      lock_r        <= 1'b0;
      lock_change_flag_r      <= 1'b0;
      irq_r         <= 1'b0;
      rd_r          <= 8'h00;
    end else if (clk_en) begin
      ctl0_r        <= ctl0_nxt;
      ctl1_r        <= ctl1_nxt;
      mult_r        <= mult_nxt;
      factor_r      <= factor_nxt;
      trim_r        <= trim_nxt;
      state_r       <= state_nxt;
      started_r     <= started_nxt;
      relock_wait_r <= relock_wait_nxt;
      lock_r        <= lock_nxt;
      lock_change_flag_r      <= lock_change_flag_nxt;
      irq_r         <= irq_nxt;
      rd_r          <= rd_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // Reset source flags
  // ---------------------------------------------------------------------
  // These sit outside the system reset so software can tell why it ran.
  always_comb begin
    power_on_flag_nxt = power_on_flag_r;
    illegal_access_flag_nxt = illegal_access_flag_r;
    if (wr_flags && reg_req.wdata[clk_gen_pkg::POWER_ON_FLAG_BIT]) begin
      power_on_flag_nxt = 1'b0;
    end
    if (wr_flags && reg_req.wdata[clk_gen_pkg::ILLEGAL_ACCESS_FLAG_BIT]) begin
      illegal_access_flag_nxt = 1'b0;
    end
    if (illegal_access) begin
      illegal_access_flag_nxt = 1'b1;
    end
    if (power_on_reset) begin
      power_on_flag_nxt = 1'b1;
      illegal_access_flag_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      power_on_flag_r <= power_on_flag_nxt;
      illegal_access_flag_r <= illegal_access_flag_nxt;
    end
  end

  assign rd_data          = rd_r;
  assign multiply_factor  = factor_r;
  assign reference_select = ctl0_r[clk_gen_pkg::REF_SEL_BIT];
  assign bus_clock_source = ctl0_r[clk_gen_pkg::BUS_SRC_BIT];
  assign osc_enable       = ctl0_r[clk_gen_pkg::OSC_EN_BIT];
  assign osc_monitor_en   = started_r;
  assign ref_trim         = trim_r;
  assign lock_irq         = irq_r;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking chk_cb @(posedge clk_sys iff clk_en);
  endclocking
  default disable iff (!rst_b);

  chk_mult_factor: assert property (
    wr_mult |=> multiply_factor ==
      clk_gen_pkg::MULT_BASE + {3'h0, $past(reg_req.wdata[6:0]), 1'b0})
    else $error("multiply factor does not match the written multiplier");

  chk_mult_clear: assert property (
    (wr_mult && !lock_change_flag_r && !illegal_access) |=> !lock_r && !lock_change_flag_r)
    else $error("multiplier write did not clear lock quietly");

  chk_trim_clear: assert property (
    (wr_trimh || wr_triml) && !lock_change_flag_r |=> !lock_r && !lock_change_flag_r)
    else $error("trim write did not clear lock quietly");

  chk_stop_clear: assert property (
    (stop_mode || wr_ctl0) |=> !lock_r ##1 !lock_r)
    else $error("stop or control write left lock set");

  chk_lock_source: assert property (
    $rose(lock_r) |-> $past(tol_sync_r) && !$past(relock_wait_r))
    else $error("lock rose without tolerance");

  chk_flag_change: assert property (
    (lock_nxt != lock_r && !force_clear) |=> lock_change_flag_r)
    else $error("lock change did not set the change flag");

  chk_irq_gate: assert property (
    lock_irq == (lock_change_flag_r && ctl1_r[clk_gen_pkg::IRQ_EN_BIT]))
    else $error("interrupt does not follow flag and enable");

  chk_por_flag: assert property (
    disable iff (1'b0) power_on_reset |=> power_on_flag_r)
    else $error("power-on did not set its flag");

  chk_illegal_access_flag_set: assert property (
    (illegal_access && !power_on_reset) |=> illegal_access_flag_r)
    else $error("illegal access flag not set");

  chk_osc_clear: assert property (
    (stop_mode || !osc_enable) |=> !osc_monitor_en)
    else $error("startup bit survived disable or stop");

  chk_ref_gate: assert property (
    (reference_select || bus_clock_source) |-> osc_monitor_en)
    else $error("oscillator chosen before startup");

  chk_trim_load: assert property (
    state_r == clk_gen_pkg::TRIM_LOAD |=> ref_trim == $past(trim_factory))
    else $error("factory trim not loaded after reset");

  chk_trimh_read: assert property (
    reg_req.rd && reg_req.addr == clk_gen_pkg::TRIMH_OFS
      |=> rd_data[7:1] == 7'h00 && rd_data[0] == $past(trim_r[8]))
    else $error("trim high byte read wrong");

  chk_set_wins: assert property (
    (lock_nxt != lock_r && !force_clear && wr_flags
      && reg_req.wdata[4]) |=> lock_change_flag_r)
    else $error("software clear beat hardware set");

  cov_lock_gain: cover property ($rose(lock_r) ##1 lock_change_flag_r);
  cov_irq_raise: cover property ($rose(lock_irq));
  cov_ref_osc:   cover property ($rose(reference_select));
  cov_relock:    cover property (wr_mult ##[1:20] $rose(lock_r));

endmodule

// [verilog/clk_gen_pkg.sv]
// Package holding the register map, field layout and types of the loop unit.
package clk_gen_pkg;

  // ---------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 8;
  localparam int MULT_W   = 7;
  localparam int TRIM_W   = 9;
  localparam int FACTOR_W = 11;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] CTL0_OFS  = 8'h34;
  localparam logic [7:0] CTL1_OFS  = 8'h35;
  localparam logic [7:0] MULT_OFS  = 8'h36;
  localparam logic [7:0] FLAGS_OFS = 8'h37;
  localparam logic [7:0] TRIMH_OFS = 8'h38;
  localparam logic [7:0] TRIML_OFS = 8'h39;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int OSC_EN_BIT  = 7;
  localparam int BUS_SRC_BIT = 3;
  localparam int REF_SEL_BIT = 2;
  localparam int IRQ_EN_BIT  = 1;
  localparam int POWER_ON_FLAG_BIT    = 6;
  localparam int LOCK_CHANGE_FLAG_BIT  = 4;
  localparam int LOCK_STATUS_BIT  = 3;
  localparam int ILLEGAL_ACCESS_FLAG_BIT    = 2;
  localparam int OSC_STARTED_BIT   = 1;
  localparam int TRIM_HI_BIT = 8;

  // ---------------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------------
  localparam logic [7:0]        CTL0_RST  = 8'h00;
  localparam logic [7:0]        CTL1_RST  = 8'h00;
  localparam logic [7:0]        CTL0_MASK = 8'hfe;
  localparam logic [7:0]        CTL1_MASK = 8'hf2;
  localparam logic [MULT_W-1:0] MULT_RST  = 7'h00;
  localparam logic [TRIM_W-1:0] TRIM_RST  = 9'h000;
  localparam logic [FACTOR_W-1:0] MULT_BASE = 11'h3e8;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  typedef enum logic [1:0] {
    TRIM_LOAD = 2'b01,
    TRIM_RUN  = 2'b10
  } trim_state_e;

endpackage

// [verif/loop_clock_regs_tb_top.sv]
// Self-checking testbench for the loop register block.
`timescale 1ns/10ps

module loop_clock_regs_tb_top;

  // ---------------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------------
  logic                                 clk_sys;
  logic                                 rst_b;
  logic                                 clk_en;
  clk_gen_pkg::reg_req_s                reg_req;
  logic [clk_gen_pkg::DATA_W-1:0]       rd_data;
  logic                                 power_on_reset;
  logic                                 illegal_access;
  logic                                 stop_mode;
  logic                                 lock_in_tol;
  logic                                 osc_start_done;
  logic [clk_gen_pkg::TRIM_W-1:0]       trim_factory;
  logic [clk_gen_pkg::FACTOR_W-1:0]     multiply_factor;
  logic                                 reference_select;
  logic                                 bus_clock_source;
  logic                                 osc_enable;
  logic                                 osc_monitor_en;
  logic [clk_gen_pkg::TRIM_W-1:0]       ref_trim;
  logic                                 lock_irq;
  int                                   err_count;
  int                                   check_count;
  logic [7:0]                           fa [4];
  logic [7:0]                           fd [4];

  loop_clock_regs loop_clock_regs_inst (
    .clk_sys          (clk_sys),
    .rst_b            (rst_b),
    .clk_en           (clk_en),
    .reg_req          (reg_req),
    .rd_data          (rd_data),
    .power_on_reset   (power_on_reset),
    .illegal_access   (illegal_access),
    .stop_mode        (stop_mode),
    .lock_in_tol      (lock_in_tol),
    .osc_start_done   (osc_start_done),
    .trim_factory     (trim_factory),
    .multiply_factor  (multiply_factor),
    .reference_select (reference_select),
    .bus_clock_source (bus_clock_source),
    .osc_enable       (osc_enable),
    .osc_monitor_en   (osc_monitor_en),
    .ref_trim         (ref_trim),
    .lock_irq         (lock_irq)
  );

  always #4 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic chk(input string n, input logic [10:0] s,
                     input logic [10:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // The request is held for one cycle; the strobe drops at the taking edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= {1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask

  // Read data stand only in the cycle after the strobe; they are sampled
  // at the edge that closes that cycle, so the read task ends on that edge.
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string n);
    @(posedge clk_sys);
    reg_req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    reg_req <= '0;
    @(posedge clk_sys);
    chk(n, 11'(rd_data), 11'(e));
  endtask

  // Lock needs the tolerance input seen low once before it may rise again.
  task automatic relock();
    lock_in_tol <= 1'b0;
    cyc(8);
    lock_in_tol <= 1'b1;
    cyc(8);
  endtask

  task automatic end_of_test();
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    end_of_test();
  end

  // ---------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0; rst_b = 1'b0; clk_en = 1'b1; reg_req = '0;
    power_on_reset = 1'b1; illegal_access = 1'b0; stop_mode = 1'b0;
    lock_in_tol = 1'b0; osc_start_done = 1'b0; trim_factory = 9'h1a5;
    err_count = 0; check_count = 0;
    fa = '{clk_gen_pkg::MULT_OFS, clk_gen_pkg::TRIMH_OFS,
           clk_gen_pkg::TRIML_OFS, clk_gen_pkg::CTL0_OFS};
    fd = '{8'h05, 8'h01, 8'h3c, 8'h00};
    cyc(16);
    rst_b <= 1'b1;
    power_on_reset <= 1'b0;
    cyc(3);
    chk("ref_trim", 11'(ref_trim), 11'h1a5);
    chk("factor", multiply_factor, 11'h3e8);
    rd(clk_gen_pkg::TRIMH_OFS, 8'h01, "trim_high");
    rd(clk_gen_pkg::TRIML_OFS, 8'ha5, "trim_low");
    rd(clk_gen_pkg::FLAGS_OFS, 8'h40, "flags_reset");
    foreach (fd[i]) begin
      wr(clk_gen_pkg::MULT_OFS, {1'b0, fd[i][6:0] ^ {7{i[0]}}});
      @(posedge clk_sys);
      chk("factor", multiply_factor,
          11'(1000 + 2 * int'(fd[i][6:0] ^ {7{i[0]}})));
    end
    wr(clk_gen_pkg::FLAGS_OFS, 8'hab);
    rd(clk_gen_pkg::FLAGS_OFS, 8'h40, "flags_ro");
    // Every forced clear of the lock, stop mode last.
    for (int i = 0; i < 5; i++) begin
      relock();
      wr(clk_gen_pkg::FLAGS_OFS, 8'h10);
      rd(clk_gen_pkg::FLAGS_OFS, 8'h48, "flags_locked");
      if (i < 4) begin
        wr(fa[i], fd[i]);
      end else begin
        stop_mode <= 1'b1;
        cyc(1);
        stop_mode <= 1'b0;
      end
      rd(clk_gen_pkg::FLAGS_OFS, 8'h40, "flags_forced");
    end
    chk("ref_trim", 11'(ref_trim), 11'h13c);
    chk("factor", multiply_factor, 11'd1010);
    relock();
    wr(clk_gen_pkg::FLAGS_OFS, 8'h10);
    wr(clk_gen_pkg::CTL1_OFS, 8'h02);
    @(posedge clk_sys);
    chk("irq_idle", 11'(lock_irq), 11'h0);
    lock_in_tol <= 1'b0;
    cyc(8);
    rd(clk_gen_pkg::FLAGS_OFS, 8'h50, "flags_unlock");
    chk("irq_on", 11'(lock_irq), 11'h1);
    wr(clk_gen_pkg::CTL1_OFS, 8'h00);
    cyc(1);
    chk("irq_masked", 11'(lock_irq), 11'h0);
    wr(clk_gen_pkg::CTL1_OFS, 8'h02);
    wr(clk_gen_pkg::FLAGS_OFS, 8'h50);
    cyc(1);
    chk("irq_clear", 11'(lock_irq), 11'h0);
    rd(clk_gen_pkg::FLAGS_OFS, 8'h00, "flags_clear");
    illegal_access <= 1'b1;
    cyc(1);
    illegal_access <= 1'b0;
    wr(clk_gen_pkg::FLAGS_OFS, 8'h00);
    rd(clk_gen_pkg::FLAGS_OFS, 8'h04, "illegal_set");
    @(posedge clk_sys);
    reg_req <= {1'b1, 1'b0, clk_gen_pkg::FLAGS_OFS, 8'h04};
    illegal_access <= 1'b1;
    @(posedge clk_sys);
    reg_req <= '0;
    illegal_access <= 1'b0;
    rd(clk_gen_pkg::FLAGS_OFS, 8'h04, "set_wins");
    wr(clk_gen_pkg::FLAGS_OFS, 8'h04);
    rd(clk_gen_pkg::FLAGS_OFS, 8'h00, "illegal_clr");
    illegal_access <= 1'b1;
    cyc(1);
    illegal_access <= 1'b0;
    rst_b <= 1'b0;
    trim_factory <= 9'h0c3;
    cyc(3);
    rst_b <= 1'b1;
    cyc(3);
    chk("reload", 11'(ref_trim), 11'h0c3);
    chk("factor_rst", multiply_factor, 11'h3e8);
    rd(clk_gen_pkg::FLAGS_OFS, 8'h04, "sys_reset");
    power_on_reset <= 1'b1;
    cyc(1);
    power_on_reset <= 1'b0;
    rd(clk_gen_pkg::FLAGS_OFS, 8'h40, "power_on");
    // Oscillator selections are refused until startup has completed.
    wr(clk_gen_pkg::CTL0_OFS, 8'h8c);
    rd(clk_gen_pkg::CTL0_OFS, 8'h80, "ctl0_early");
    chk("ref_early", 11'(reference_select), 11'h0);
    chk("bus_early", 11'(bus_clock_source), 11'h0);
    chk("mon_early", 11'(osc_monitor_en), 11'h0);
    chk("osc_en", 11'(osc_enable), 11'h1);
    osc_start_done <= 1'b1;
    cyc(8);
    rd(clk_gen_pkg::FLAGS_OFS, 8'h42, "started");
    chk("mon_on", 11'(osc_monitor_en), 11'h1);
    wr(clk_gen_pkg::CTL0_OFS, 8'h8c);
    rd(clk_gen_pkg::CTL0_OFS, 8'h8c, "ctl0_sel");
    chk("ref_osc", 11'(reference_select), 11'h1);
    chk("bus_osc", 11'(bus_clock_source), 11'h1);
    stop_mode <= 1'b1;
    cyc(3);
    chk("ref_stop", 11'(reference_select), 11'h0);
    chk("bus_stop", 11'(bus_clock_source), 11'h0);
    chk("mon_stop", 11'(osc_monitor_en), 11'h0);
    rd(clk_gen_pkg::FLAGS_OFS, 8'h40, "stop_flags");
    stop_mode <= 1'b0;
    cyc(8);
    wr(clk_gen_pkg::CTL0_OFS, 8'h00);
    cyc(3);
    rd(clk_gen_pkg::FLAGS_OFS, 8'h40, "osc_off");
    chk("mon_off", 11'(osc_monitor_en), 11'h0);
    rd(8'h3a, 8'h00, "unmapped");
    cyc(1);
    chk("rd_idle", 11'(rd_data), 11'h0);
    end_of_test();
  end

endmodule
